// ### src/dbs_pkg.sv
// constants and types shared by the burst sram port files
package dbs_pkg;

  // ----------------------------------------------------------------
  // organisation
  // ----------------------------------------------------------------
  localparam int BYTE_W = 9;        // one byte lane incl. parity bit
  localparam int ADDR_W_DEF = 21;   // burst address width, x18 part
  localparam int DATA_W_DEF = 18;   // word width, x18 part
  localparam int FIFO_DEPTH = 4;    // posted write buffer depth

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;  // ref_clk period
  localparam int SYNC_STAGES = 2;     // flops ahead of any pin logic

  // ----------------------------------------------------------------
  // burst and read pipeline
  // ----------------------------------------------------------------
  localparam logic BURST_FIRST = 1'b0;   // word at latched address
  localparam logic BURST_SECOND = 1'b1;  // word at next burst address
  localparam int RD_PIPE = 3;            // K cycles a read is tracked
  localparam int RD_STG_STD = 2;         // both words, 2.5 cycle mode
  localparam int RD_STG_LEG_W0 = 0;      // first word, 1 cycle mode
  localparam int RD_STG_LEG_W1 = 1;      // second word, 1 cycle mode
  localparam logic OE_RESET = 1'b0;      // outputs float after reset

  // write data capture sequence
  typedef enum logic [1:0] {
    WR_IDLE  = 2'b00,
    WR_WORD0 = 2'b01,
    WR_WORD1 = 2'b10
  } dbs_wr_state_t;

endpackage

// ### src/dbs_fifo.sv
// posted write buffer with valid/ready on both sides
module dbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = dbs_pkg::FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import dbs_pkg::*;

  // ----------------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];  // entry flops
  logic [PW-1:0] wr_ptr_r;          // next slot to fill
  logic [PW-1:0] rd_ptr_r;          // oldest entry
  logic [CW-1:0] cnt_r;             // entries held
  logic push;
  logic pop;

  // wrapping pointer step
  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // honest full and empty
  assign in_ready = (cnt_r != FULL_CNT);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // entry write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= ptr_inc(wr_ptr_r);
      end
      if (pop) begin
        rd_ptr_r <= ptr_inc(rd_ptr_r);
      end
      if (push && !pop) begin
        cnt_r <= CW'(cnt_r + 1'b1);
      end else if (pop && !push) begin
        cnt_r <= CW'(cnt_r - 1'b1);
      end
    end
  end

endmodule

// ### src/dbs_array.sv
// word array with per-byte write selects and one read port
module dbs_array #(
  parameter int IDX_W = dbs_pkg::ADDR_W_DEF + 1,
  parameter int DATA_W = dbs_pkg::DATA_W_DEF
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [IDX_W-1:0] wr_idx,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic [DATA_W/dbs_pkg::BYTE_W-1:0] wr_sel_n,
  input wire logic [IDX_W-1:0] rd_idx,
  output logic [DATA_W-1:0] rd_data
);
  import dbs_pkg::*;

  localparam int BW = DATA_W / BYTE_W;  // byte lanes

  logic [DATA_W-1:0] mem_r [2**IDX_W];  // array contents

  // lanes with select high keep their value
  always_ff @(posedge ref_clk) begin
    for (int b = 0; b < BW; b++) begin
      if (wr_en && !wr_sel_n[b]) begin
        mem_r[wr_idx][b*BYTE_W +: BYTE_W] <= wr_data[b*BYTE_W +: BYTE_W];
      end
    end
  end

  assign rd_data = mem_r[rd_idx];

endmodule

// ### src/dbs_port.sv
// command and data port of a two-word burst ddr sram
//
// Summary of operation
// - write: word0 next K, word1 next K-bar
// - read: words at K-bar t+2, K t+3
// - word0 at latched address, word1 next
// - capture and launch on both clock rises
// - stopped clocks hold data pins unchanged
// - x18: two selects gate two byte lanes
// - x36: four selects gate four byte lanes
// - selects sampled separately per data half
// - power up deselected, outputs floating
// - pll disabled: one cycle read latency
module dbs_port #(
  parameter int ADDR_W = dbs_pkg::ADDR_W_DEF,
  parameter int DATA_W = dbs_pkg::DATA_W_DEF
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W/dbs_pkg::BYTE_W-1:0] byte_write_select_n,
  input wire logic pll_disable_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic write_buf_ready
);
  import dbs_pkg::*;

  // ----------------------------------------------------------------
  // derived sizes
  // ----------------------------------------------------------------
  localparam int BW = DATA_W / BYTE_W;         // byte lanes per word
  localparam int IDX_W = ADDR_W + 1;           // array word index
  localparam int ENT_W = IDX_W + DATA_W + BW;  // buffered write entry

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic k_s1_r, k_s2_r, k_s3_r;        // positive clock pin
  logic kn_s1_r, kn_s2_r, kn_s3_r;     // negative clock pin
  logic ld_s1_r, ld_s2_r;              // load strobe, active low
  logic rnw_s1_r, rnw_s2_r;            // read not write
  logic pll_s1_r, pll_s2_r;            // pll enable strap
  logic [ADDR_W-1:0] addr_s1_r;        // burst address
  logic [ADDR_W-1:0] addr_s2_r;
  logic [DATA_W-1:0] din_s1_r;         // write data
  logic [DATA_W-1:0] din_s2_r;
  logic [BW-1:0] bws_s1_r;             // byte selects, active low
  logic [BW-1:0] bws_s2_r;

  // two flops on every pin; clocks park high so no false edge
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // pins read as idle: clocks high, no command
      k_s1_r <= 1'b1;
      k_s2_r <= 1'b1;
      k_s3_r <= 1'b1;
      kn_s1_r <= 1'b1;
      kn_s2_r <= 1'b1;
      kn_s3_r <= 1'b1;
      ld_s1_r <= 1'b1;
      ld_s2_r <= 1'b1;
      rnw_s1_r <= 1'b0;
      rnw_s2_r <= 1'b0;
      pll_s1_r <= 1'b1;
      pll_s2_r <= 1'b1;
    end else begin
      k_s1_r <= k_clk;
      k_s2_r <= k_s1_r;
      k_s3_r <= k_s2_r;
      kn_s1_r <= k_clk_n;
      kn_s2_r <= kn_s1_r;
      kn_s3_r <= kn_s2_r;
      ld_s1_r <= load_strobe_n;
      ld_s2_r <= ld_s1_r;
      rnw_s1_r <= read_not_write;
      rnw_s2_r <= rnw_s1_r;
      pll_s1_r <= pll_disable_n;
      pll_s2_r <= pll_s1_r;
    end
  end

  // data path pins, same depth as the clocks to stay aligned
  always_ff @(posedge ref_clk) begin
    addr_s1_r <= addr;
    addr_s2_r <= addr_s1_r;
    din_s1_r <= data_in;
    din_s2_r <= din_s1_r;
    bws_s1_r <= byte_write_select_n;
    bws_s2_r <= bws_s1_r;
  end

  // ----------------------------------------------------------------
  // clock edge events and command decode
  // ----------------------------------------------------------------
  logic k_rise;    // positive clock rose
  logic kn_rise;   // negative clock rose
  logic tick;      // either rise, a half-cycle slot
  logic cmd_rd;    // read started this K rise
  logic cmd_wr;    // write started this K rise
  logic std_mode;  // 2.5 cycle latency when pll enabled

  // stopped clocks give no events, so all state holds except the write buffer, which keeps draining
  assign k_rise = k_s2_r & ~k_s3_r;
  assign kn_rise = kn_s2_r & ~kn_s3_r;
  assign tick = k_rise | kn_rise;
  // strobe high: nothing starts, direction ignored
  assign cmd_rd = k_rise & ~ld_s2_r & rnw_s2_r;
  assign cmd_wr = k_rise & ~ld_s2_r & ~rnw_s2_r;
  assign std_mode = pll_s2_r;

  // ----------------------------------------------------------------
  // write capture sequence
  // ----------------------------------------------------------------
  dbs_wr_state_t wr_state_r;        // which data half is expected
  logic [ADDR_W-1:0] wr_addr_r;     // address of burst in progress
  logic [ADDR_W-1:0] wr_next_r;     // address of queued burst
  logic wr_pend_r;                  // a burst waits behind this one

  // data follows the command by one K; back to back bursts queue
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      wr_state_r <= WR_IDLE;
      wr_addr_r <= '0;
      wr_next_r <= '0;
      wr_pend_r <= 1'b0;
    end else if (k_rise) begin
      unique case (wr_state_r)
        // first half taken now, second on K-bar
        WR_WORD0: begin
          wr_state_r <= WR_WORD1;
          if (cmd_wr) begin
            wr_next_r <= addr_s2_r;
            wr_pend_r <= 1'b1;
          end
        end
        // idle, or a K-bar half went missing: start afresh
        WR_IDLE, WR_WORD1: begin
          wr_pend_r <= 1'b0;
          if (cmd_wr) begin
            wr_addr_r <= addr_s2_r;
            wr_state_r <= WR_WORD0;
          end else begin
            wr_state_r <= WR_IDLE;
          end
        end
      endcase
    end else if (kn_rise && wr_state_r == WR_WORD1) begin
      // second half done; pick up a queued burst
      wr_state_r <= wr_pend_r ? WR_WORD0 : WR_IDLE;
      wr_addr_r <= wr_next_r;
      wr_pend_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // posted write buffer and array
  // ----------------------------------------------------------------
  logic push_valid;               // a data half is captured
  logic push_burst;               // which half of the burst
  logic [ENT_W-1:0] push_data;    // index, data, selects
  logic buf_valid;                // buffer holds an entry
  logic [ENT_W-1:0] buf_data;     // oldest entry
  logic drain;                    // entry goes to the array
  logic [IDX_W-1:0] rd_idx;       // word index being launched
  logic [DATA_W-1:0] rd_word;     // array word at rd_idx

  // each half captured with its own selects
  assign push_valid = (k_rise & (wr_state_r == WR_WORD0))
                    | (kn_rise & (wr_state_r == WR_WORD1));
  assign push_burst = (wr_state_r == WR_WORD1) ? BURST_SECOND : BURST_FIRST;
  assign push_data = {wr_addr_r, push_burst, din_s2_r, bws_s2_r};

  // buffer drain yields to launch slots so a launch sees stable data
  assign drain = buf_valid & ~tick;

  dbs_fifo #(
    .WIDTH(ENT_W),
    .DEPTH(FIFO_DEPTH)
  ) u_wbuf (
    .ref_clk(ref_clk),
    .srst(srst),
    .in_valid(push_valid),
    .in_ready(write_buf_ready),
    .in_data(push_data),
    .out_valid(buf_valid),
    .out_ready(~tick),
    .out_data(buf_data)
  );

  // lanes with select high stay unaltered
  dbs_array #(
    .IDX_W(IDX_W),
    .DATA_W(DATA_W)
  ) u_array (
    .ref_clk(ref_clk),
    .wr_en(drain),
    .wr_idx(buf_data[ENT_W-1 -: IDX_W]),
    .wr_data(buf_data[BW +: DATA_W]),
    .wr_sel_n(buf_data[BW-1:0]),
    .rd_idx(rd_idx),
    .rd_data(rd_word)
  );

  // ----------------------------------------------------------------
  // read pipeline, one stage per K cycle
  // ----------------------------------------------------------------
  logic [RD_PIPE-1:0] rd_v_r;        // stage holds a read
  logic [ADDR_W-1:0] rd_a_r [RD_PIPE];  // address per stage

  // every K rise ages the outstanding reads by one cycle
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      // no reads in flight after power up
      rd_v_r <= '0;
    end else if (k_rise) begin
      rd_v_r <= {rd_v_r[RD_PIPE-2:0], cmd_rd};
    end
  end

  // addresses travel with the valid bits
  always_ff @(posedge ref_clk) begin
    if (k_rise) begin
      rd_a_r[0] <= addr_s2_r;
      for (int i = 1; i < RD_PIPE; i++) begin
        rd_a_r[i] <= rd_a_r[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // launch slot selection
  // ----------------------------------------------------------------
  logic rd_go;   // a word is launched at this tick

  // stage and half chosen by latency mode
  always_comb begin
    // no launch unless a clock rise picks one
    rd_go = 1'b0;
    rd_idx = '0;
    if (k_rise) begin
      if (std_mode) begin
        // second word at K of t+3
        rd_go = rd_v_r[RD_STG_STD];
        rd_idx = {rd_a_r[RD_STG_STD], BURST_SECOND};
      end else begin
        // legacy: first word at K of t+1
        rd_go = rd_v_r[RD_STG_LEG_W0];
        rd_idx = {rd_a_r[RD_STG_LEG_W0], BURST_FIRST};
      end
    end else if (kn_rise) begin
      if (std_mode) begin
        // first word at K-bar of t+2
        rd_go = rd_v_r[RD_STG_STD];
        rd_idx = {rd_a_r[RD_STG_STD], BURST_FIRST};
      end else begin
        // legacy: second word at K-bar of t+1
        rd_go = rd_v_r[RD_STG_LEG_W1];
        rd_idx = {rd_a_r[RD_STG_LEG_W1], BURST_SECOND};
      end
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  // outputs move only on clock rises; float at the first empty slot
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_oe <= OE_RESET;
    end else if (tick) begin
      data_oe <= rd_go;
    end
  end

  // data held between slots and while clocks are stopped
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      data_out <= '0;
    end else if (tick && rd_go) begin
      data_out <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // limitations
  // ----------------------------------------------------------------
  // read to write turnaround idles are left to the controller
  // a read fetches the array at launch; a write still queued in the
  // buffer at that moment is not seen, which needs a write landing
  // less than one K cycle before the launch
  // halves come faster than the buffer drains only with a very fast
  // K; a half offered while the buffer is full is dropped
  // a latency mode change with reads in flight is not defined

endmodule

// ### sim/dbs_port_asserts.sv
// pin level assertions for the burst sram port
module dbs_port_asserts #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 36
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic k_clk,
  input wire logic k_clk_n,
  input wire logic load_strobe_n,
  input wire logic read_not_write,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W/dbs_pkg::BYTE_W-1:0] byte_write_select_n,
  input wire logic pll_disable_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic write_buf_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  import dbs_pkg::*;
  // ----
  // helper logic
  // ----
  logic k_q;  // pin clocks one cycle ago
  logic kb_q;
  logic [2:0] kp_r;  // delayed rise flags of each pin clock
  logic [2:0] bp_r;
  logic [2:0] rd_k_r;  // K rises since the last read, saturating
  logic [2:0] rd_h_r;  // read seen at each of the last three K rises
  // rise flags delayed to the launch edge
  always_ff @(posedge ref_clk) begin
    k_q <= k_clk;
    kb_q <= k_clk_n;
    if (srst) begin
      kp_r <= 3'h0;
      bp_r <= 3'h0;
    end else begin
      kp_r <= {kp_r[1:0], k_clk & ~k_q};
      bp_r <= {bp_r[1:0], k_clk_n & ~kb_q};
    end
  end
  // read age in clock cycles
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rd_k_r <= 3'h7;
      rd_h_r <= 3'h0;
    end else if (k_clk & ~k_q) begin
      rd_h_r <= {rd_h_r[1:0], !load_strobe_n && read_not_write};
      if (!load_strobe_n && read_not_write) rd_k_r <= 3'h0;
      else if (rd_k_r != 3'h7) rd_k_r <= rd_k_r + 3'h1;
    end
  end
  // ----
  // assertions
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  AST_RESET_FLOAT: assert property (disable iff (1'b0) srst |=> !data_oe && data_out == '0)
    else $error("outputs not idle after reset");
  AST_OUT_ON_EDGE: assert property (($changed(data_out) || $changed(data_oe)) |-> (kp_r[2] || bp_r[2]))
    else $error("output moved without a clock rise");
  AST_IDLE_FLOAT: assert property (rd_k_r > 3'h3 |-> !data_oe)
    else $error("output driven with no read pending");
  AST_OE_RISE: assert property ($rose(data_oe) |->
    (pll_disable_n ? (bp_r[2] && rd_h_r[2]) : (kp_r[2] && rd_h_r[1])))
    else $error("output enable rose at wrong latency");
  AST_READ_LAUNCH: assert property (bp_r[2] && rd_k_r == 3'h2 && pll_disable_n |-> data_oe)
    else $error("first read word not launched");
  AST_FLOAT_AFTER: assert property (bp_r[2] && rd_k_r == 3'h3 && pll_disable_n |-> !data_oe)
    else $error("output not floated after burst");
  AST_LEG_LAUNCH: assert property (kp_r[2] && rd_k_r == 3'h1 && !pll_disable_n |-> data_oe)
    else $error("legacy read word not launched");
  AST_LEG_FLOAT: assert property (kp_r[2] && rd_k_r == 3'h2 && !pll_disable_n |-> !data_oe)
    else $error("legacy output not floated");
endmodule

bind dbs_port dbs_port_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) dbs_port_asserts_i (
  .ref_clk(ref_clk), .srst(srst), .k_clk(k_clk), .k_clk_n(k_clk_n),
  .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
  .data_in(data_in), .byte_write_select_n(byte_write_select_n), .pll_disable_n(pll_disable_n),
  .data_out(data_out), .data_oe(data_oe), .write_buf_ready(write_buf_ready));

// ### sim/dbs_ctrl_model.sv
// memory controller model driving the sram port pins
module dbs_ctrl_model #(
  parameter int ADDR_W = 4,
  parameter int DATA_W = 36
) (
  input wire logic ref_clk,
  output logic k_clk,
  output logic k_clk_n,
  output logic load_strobe_n,
  output logic read_not_write,
  output logic [ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] data_in,
  output logic [DATA_W/dbs_pkg::BYTE_W-1:0] byte_write_select_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import dbs_pkg::*;
  localparam int NL = DATA_W / BYTE_W;  // byte lanes
  logic [DATA_W-1:0] q_smp;  // read word seen late in a half
  logic oe_smp;  // enable seen late in a half
  // pins idle, clocks stopped
  initial begin
    k_clk = 1'b0;
    k_clk_n = 1'b1;
    load_strobe_n = 1'b1;
    read_not_write = 1'b0;
    addr = '0;
    data_in = '0;
    byte_write_select_n = '1;
  end
  // one clock half: raise a clock, hold four cycles, sample
  task automatic half(input logic hi);
    @(posedge ref_clk);
    k_clk <= hi;
    k_clk_n <= !hi;
    repeat (4) @(posedge ref_clk);
    #1;
    q_smp = data_out;
    oe_smp = data_oe;
  endtask
  // positive clock half with command and data; undriven lines toggle
  task automatic khalf(input logic cmd_n, input logic rnw, input logic [ADDR_W-1:0] a,
                       input logic drv, input logic [DATA_W-1:0] d, input logic [NL-1:0] sel);
    @(posedge ref_clk);
    load_strobe_n <= cmd_n;
    read_not_write <= rnw;
    addr <= cmd_n ? ~addr : a;
    data_in <= drv ? d : ~data_in;
    byte_write_select_n <= drv ? sel : ~byte_write_select_n;
    half(1'b1);
  endtask
  // negative clock half carrying the second word
  task automatic kbhalf(input logic drv, input logic [DATA_W-1:0] d, input logic [NL-1:0] sel);
    @(posedge ref_clk);
    data_in <= drv ? d : ~data_in;
    byte_write_select_n <= drv ? sel : ~byte_write_select_n;
    half(1'b0);
  endtask
endmodule

// ### sim/tb.sv
// self-checking bench for the burst sram port
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import dbs_pkg::*;
  localparam int AW = 4;  // small array
  localparam int DW = 36;  // four lane organisation
  localparam int NL = DW / BYTE_W;
  logic ref_clk = 1'b0;
  logic srst = 1'b1;
  logic pll_disable_n = 1'b1;
  logic k_clk, k_clk_n, load_strobe_n, read_not_write, data_oe, write_buf_ready;
  logic [AW-1:0] addr;
  logic [DW-1:0] data_in, data_out;
  logic [NL-1:0] byte_write_select_n;
  logic [DW-1:0] mem [0:2**(AW+1)-1];  // expected array contents
  int n_fail = 0;
  int comparisons = 0;
  always #5 ref_clk = ~ref_clk;
  dbs_port #(.ADDR_W(AW), .DATA_W(DW)) dbs_port_i (.ref_clk(ref_clk), .srst(srst), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
    .data_in(data_in), .byte_write_select_n(byte_write_select_n), .pll_disable_n(pll_disable_n),
    .data_out(data_out), .data_oe(data_oe), .write_buf_ready(write_buf_ready));
  dbs_ctrl_model #(.ADDR_W(AW), .DATA_W(DW)) dbs_ctrl_model_i (.ref_clk(ref_clk), .k_clk(k_clk),
    .k_clk_n(k_clk_n), .load_strobe_n(load_strobe_n), .read_not_write(read_not_write), .addr(addr),
    .data_in(data_in), .byte_write_select_n(byte_write_select_n), .data_out(data_out), .data_oe(data_oe));
  // ----
  // compare and report
  // ----
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----
  // stimulus helpers
  // ----
  function automatic logic [DW-1:0] pat(input int i, input int s);
    for (int l = 0; l < NL; l++) pat[l*BYTE_W +: BYTE_W] = 9'(i * 5 + s + l);
  endfunction
  // lane merge into the expected array
  task automatic put(input int i, input logic [DW-1:0] d, input logic [NL-1:0] sel);
    for (int l = 0; l < NL; l++) if (!sel[l]) mem[i][l*BYTE_W +: BYTE_W] = d[l*BYTE_W +: BYTE_W];
  endtask
  // n back to back writes from base, data one cycle behind each command
  task automatic writes(input int n, input int base, input int s, input logic [NL-1:0] s0,
                        input logic [NL-1:0] s1);
    int a;
    for (int c = 0; c <= n; c++) begin
      a = (base + c - 1) * 2;
      dbs_ctrl_model_i.khalf(c == n, 1'b0, AW'(base + c), c > 0, pat(a, s), s0);
      dbs_ctrl_model_i.kbhalf(c > 0, pat(a + 1, s), s1);
      if (c > 0) put(a, pat(a, s), s0);
      if (c > 0) put(a + 1, pat(a + 1, s), s1);
    end
  endtask
  // n back to back reads, then four idle cycles with read level held
  task automatic reads(input int n, input int base, input bit stop);
    int j;
    for (int c = 0; c < n + 4; c++) begin
      dbs_ctrl_model_i.khalf(c >= n, 1'b1, AW'(base + c), 1'b0, '0, '1);
      j = pll_disable_n ? c - 3 : c - 1;
      if (j >= 0 && j < n) begin
        chk_flag(dbs_ctrl_model_i.oe_smp, 1'b1);
        chk_word(dbs_ctrl_model_i.q_smp, mem[(base + j) * 2 + (pll_disable_n ? 1 : 0)]);
      end else if (c == n + 1 && !pll_disable_n) chk_flag(dbs_ctrl_model_i.oe_smp, 1'b0);
      dbs_ctrl_model_i.kbhalf(1'b0, '0, '1);
      j = pll_disable_n ? c - 2 : c - 1;
      if (j >= 0 && j < n) begin
        chk_flag(dbs_ctrl_model_i.oe_smp, 1'b1);
        chk_word(dbs_ctrl_model_i.q_smp, mem[(base + j) * 2 + (pll_disable_n ? 0 : 1)]);
      end else if (c == n + 2 && pll_disable_n) chk_flag(dbs_ctrl_model_i.oe_smp, 1'b0);
      if (stop && c == 2) begin
        repeat (30) @(posedge ref_clk);
        chk_word(data_out, mem[base * 2]);
        chk_flag(data_oe, 1'b1);
      end
    end
  endtask
  // ----
  // scenarios
  // ----
  task automatic sc_idle();
    chk_flag(data_oe, 1'b0);
    chk_word(data_out, '0);
    chk_flag(write_buf_ready, 1'b1);
    reads(0, 0, 1'b0);
    chk_flag(dbs_ctrl_model_i.oe_smp, 1'b0);
  endtask
  task automatic sc_basic();
    writes(1, 3, 0, '0, '0);
    reads(1, 3, 1'b0);
  endtask
  task automatic sc_pipe();
    writes(3, 8, 16, '0, '0);
    reads(3, 8, 1'b0);
  endtask
  task automatic sc_lanes();
    writes(1, 12, 32, '0, '0);
    for (int l = 0; l < NL; l++) writes(1, 12, 40 + l, ~(NL'(1) << l), ~(NL'(8) >> l));
    writes(1, 12, 60, '1, '1);
    reads(1, 12, 1'b0);
  endtask
  // reset again in mid-run with a read word still on the outputs
  task automatic sc_reset();
    @(posedge ref_clk);
    srst <= 1'b1;
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    chk_flag(data_oe, 1'b0);
    chk_word(data_out, '0);
    chk_flag(write_buf_ready, 1'b1);
  endtask
  task automatic sc_legacy();
    @(posedge ref_clk);
    pll_disable_n <= 1'b0;
    reads(2, 8, 1'b0);
    @(posedge ref_clk);
    pll_disable_n <= 1'b1;
  endtask
  task automatic sc_stop();
    reads(1, 3, 1'b1);
  endtask
  // ----
  // main sequence and watchdog
  // ----
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    #1;
    sc_idle();
    sc_basic();
    sc_pipe();
    sc_lanes();
    sc_reset();
    sc_legacy();
    sc_stop();
    summarize();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    summarize();
  end
endmodule
